// ===== dicm_pkg.sv
// Constants and types shared by the dual-input channel mapper
package dicm_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CONV = 16;
  localparam int SAMPLE_W = 14;
  localparam int GAIN_W = 8;
  localparam int OFS_W = 8;
  localparam int CORNER_W = 3;
  localparam int HPF_GROUP = 4;
  localparam int GAIN_SHIFT = 8;
  localparam int AXI_AW = 12;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PDN = 12'h008;
  localparam logic [11:0] ADDR_HPF = 12'h00C;
  localparam logic [11:0] ADDR_TRIM_BASE = 12'h100;
  localparam int TRIM_STRIDE = 8;
  localparam int TRIM_EVEN_OFS = 4;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTRL_MODE32_BIT = 0;
  localparam int CTRL_RATE2X_BIT = 1;
  localparam int ST_PHASE_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int PDN_ANA_LSB = 16;
  localparam int HPF_CORNER_LSB = 4;
  localparam int TRIM_GAIN_LSB = 8;
  localparam int TRIM_OFS_LSB = 0;
  localparam logic MODE32_RST = 1'b1;
  localparam logic [7:0] GAIN_RST = 8'h80;
  localparam logic [7:0] OFS_RST = 8'h00;
  localparam logic [8:0] GAIN_UNITY_BIAS = 9'h080;

  // ****************************************
  // Bus answers and types
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic {PH_ODD, PH_EVEN} dicm_phase_t;

endpackage

// ===== dicm_trim_unit.sv
// Gain and offset trim of one converter word, with digital power-down
`timescale 1ns/1ps
`default_nettype none
module dicm_trim_unit
  import dicm_pkg::*;
#(
  parameter int SW = SAMPLE_W
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Incoming conversion
  input wire logic inValid,
  input wire logic inEven,
  input wire logic pdn,
  input wire logic [SW-1:0] sample,
  input wire logic [GAIN_W-1:0] gain,
  input wire logic [OFS_W-1:0] offset,
  // Trimmed word
  output logic outValid_r,
  output logic outEven_r,
  output logic [SW-1:0] outWord_r
);

  logic [8:0] scale;
  logic signed [SW+9:0] prod;
  logic signed [SW+9:0] shifted;
  logic [SW-1:0] sum;

  // Gain code 0x80 is unity, range one half to about one and a half
  assign scale = {1'b0, gain} + GAIN_UNITY_BIAS;
  assign prod = $signed(sample) * $signed({1'b0, scale});
  assign shifted = prod >>> GAIN_SHIFT;
  assign sum = shifted[SW-1:0] + {{(SW-OFS_W){offset[OFS_W-1]}}, offset};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      outValid_r <= 1'b0;
      outEven_r <= 1'b0;
      outWord_r <= '0;
    end else if (ce) begin
      outValid_r <= inValid;
      if (inValid) begin
        outEven_r <= inEven;
        outWord_r <= pdn ? '0 : sum;
      end
    end
  end

endmodule // dicm_trim_unit
`default_nettype wire

// ===== dicm_mapper_top.sv
// Thirty-two-input sample ordering and channel mapping for 16 converters
// Notes on behaviour
// - At 1X rate converter k takes input 2k-1 first, 2k second, both in one frame on lane k.
// - In thirty-two-input mode each converter alternates between its two inputs.
// - The doubled rate is never used in thirty-two-input mode; 1X stays selected.
// - The odd-input conversion is the odd sample word and takes the odd frame slot.
// - The even-input conversion is the even sample word and takes the even frame slot.
// - Odd trims apply only to channel 2k-1, even trims only to channel 2k.
// - Digital power-down of a converter acts on both its channels together.
// - Analog power-down of a converter acts on both its channels together.
// - High-pass enable and corner of a four-converter group govern its eight channels.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module dicm_mapper_top
  import dicm_pkg::*;
#(
  parameter int NCONV = NUM_CONV,
  parameter int SW = SAMPLE_W
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // Converter results
  input wire logic convValid,
  input wire logic [NCONV*SW-1:0] convData,
  // Front-end controls
  output logic muxSelEven,
  output logic rateSel2x,
  output logic [2*NCONV-1:0] chanAnaPdn,
  output logic [2*NCONV-1:0] chanHpfEn,
  output logic [2*NCONV*CORNER_W-1:0] chanHpfCorner,
  // Frames toward the lane serializers
  output logic frameValid,
  output logic [NCONV*2*SW-1:0] laneFrame,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int NGRP = NCONV / HPF_GROUP;

  if (NCONV % HPF_GROUP != 0 || NCONV < HPF_GROUP || NCONV > 16 ||
      SW < OFS_W || SW > 16) begin : g_chk
    $error("dicm_mapper_top: unsupported parameters");
  end

  // ****************************************
  // Configuration state
  // ****************************************
  logic mode32_r;
  logic refused_r;
  logic [NCONV-1:0] pdnDig_r;
  logic [NCONV-1:0] pdnAna_r;
  logic [NGRP-1:0] hpfEn_r;
  logic [NGRP*CORNER_W-1:0] hpfCorner_r;
  logic [15:0] oddTrim_r [NCONV];
  logic [15:0] evenTrim_r [NCONV];
  dicm_phase_t phase_r;

  logic [AXI_AW-1:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic doWrite;
  logic wrHit;
  logic [31:0] rdMux;
  logic rdHit;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb begin
    wrHit = (awAddr_r == ADDR_CTRL) || (awAddr_r == ADDR_STATUS) ||
            (awAddr_r == ADDR_PDN) || (awAddr_r == ADDR_HPF);
    for (int k = 0; k < NCONV; k++) begin
      if (awAddr_r == ADDR_TRIM_BASE + 12'(k * TRIM_STRIDE) ||
          awAddr_r == ADDR_TRIM_BASE + 12'(k * TRIM_STRIDE + TRIM_EVEN_OFS)) begin
        wrHit = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Register updates
  // ****************************************
  logic [31:0] ctrlImg;
  logic rateReq;
  assign ctrlImg = merge({30'h0, rateSel2x, mode32_r}, wData_r, wStrb_r);
  assign rateReq = doWrite && awAddr_r == ADDR_CTRL &&
                   ctrlImg[CTRL_RATE2X_BIT] && ctrlImg[CTRL_MODE32_BIT];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode32_r <= MODE32_RST;
      rateSel2x <= 1'b0;
      pdnDig_r <= '0;
      pdnAna_r <= '0;
      hpfEn_r <= '0;
      hpfCorner_r <= '0;
      for (int k = 0; k < NCONV; k++) begin
        oddTrim_r[k] <= {GAIN_RST, OFS_RST};
        evenTrim_r[k] <= {GAIN_RST, OFS_RST};
      end
    end else if (ce && doWrite) begin
      if (awAddr_r == ADDR_CTRL) begin
        mode32_r <= ctrlImg[CTRL_MODE32_BIT];
        // Doubled rate only accepted outside thirty-two-input mode
        rateSel2x <= ctrlImg[CTRL_RATE2X_BIT] && !ctrlImg[CTRL_MODE32_BIT];
      end
      if (awAddr_r == ADDR_PDN) begin
        pdnDig_r <= NCONV'(merge(32'(pdnDig_r), wData_r, wStrb_r));
        pdnAna_r <= NCONV'(merge(32'(pdnAna_r) << PDN_ANA_LSB, wData_r,
                                 wStrb_r) >> PDN_ANA_LSB);
      end
      if (awAddr_r == ADDR_HPF) begin
        hpfEn_r <= NGRP'(merge(32'(hpfEn_r), wData_r, wStrb_r));
        hpfCorner_r <= (NGRP*CORNER_W)'(merge(32'(hpfCorner_r) <<
            HPF_CORNER_LSB, wData_r, wStrb_r) >> HPF_CORNER_LSB);
      end
      for (int k = 0; k < NCONV; k++) begin
        if (awAddr_r == ADDR_TRIM_BASE + 12'(k * TRIM_STRIDE)) begin
          oddTrim_r[k] <= 16'(merge(32'(oddTrim_r[k]), wData_r, wStrb_r));
        end
        if (awAddr_r == ADDR_TRIM_BASE +
            12'(k * TRIM_STRIDE + TRIM_EVEN_OFS)) begin
          evenTrim_r[k] <= 16'(merge(32'(evenTrim_r[k]), wData_r, wStrb_r));
        end
      end
    end
  end

  // Refused doubled-rate request is sticky; a new refusal beats the clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      refused_r <= 1'b0;
    end else if (ce) begin
      if (rateReq) begin
        refused_r <= 1'b1;
      end else if (doWrite && awAddr_r == ADDR_STATUS && wStrb_r[0] &&
                   wData_r[ST_REFUSED_BIT]) begin
        refused_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always_comb begin
    rdMux = 32'h0000_0000;
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL: rdMux = {30'h0, rateSel2x, mode32_r};
      ADDR_STATUS: rdMux = {30'h0, refused_r, phase_r == PH_EVEN};
      ADDR_PDN: rdMux = (32'(pdnAna_r) << PDN_ANA_LSB) | 32'(pdnDig_r);
      ADDR_HPF: rdMux = (32'(hpfCorner_r) << HPF_CORNER_LSB) | 32'(hpfEn_r);
      default: begin
        rdHit = 1'b0;
        for (int k = 0; k < NCONV; k++) begin
          if (s_axi_araddr == ADDR_TRIM_BASE + 12'(k * TRIM_STRIDE)) begin
            rdMux = 32'(oddTrim_r[k]);
            rdHit = 1'b1;
          end
          if (s_axi_araddr == ADDR_TRIM_BASE +
              12'(k * TRIM_STRIDE + TRIM_EVEN_OFS)) begin
            rdMux = 32'(evenTrim_r[k]);
            rdHit = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Sampling phase
  // ****************************************
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase_r <= PH_ODD;
      muxSelEven <= 1'b0;
    end else if (ce) begin
      if (!mode32_r) begin
        phase_r <= PH_ODD;
        muxSelEven <= 1'b0;
      end else if (convValid) begin
        // Odd input at t1, even input at t2, then back
        phase_r <= (phase_r == PH_ODD) ? PH_EVEN : PH_ODD;
        muxSelEven <= (phase_r == PH_ODD);
      end
    end
  end

  // ****************************************
  // Per-converter trim and frame assembly
  // ****************************************
  logic [NCONV-1:0] trValid;
  logic [NCONV-1:0] trEven;
  logic [SW-1:0] trWord [NCONV];
  logic [SW-1:0] oddHold_r [NCONV];
  logic [15:0] selTrim [NCONV];

  for (genvar k = 0; k < NCONV; k++) begin : g_conv
    // Trim set follows the input being converted
    assign selTrim[k] = (phase_r == PH_ODD) ? oddTrim_r[k] : evenTrim_r[k];

    dicm_trim_unit #(.SW(SW)) u_trim (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .inValid(convValid && mode32_r),
      .inEven(phase_r == PH_EVEN),
      .pdn(pdnDig_r[k]),
      .sample(convData[k*SW +: SW]),
      .gain(selTrim[k][TRIM_GAIN_LSB +: GAIN_W]),
      .offset(selTrim[k][TRIM_OFS_LSB +: OFS_W]),
      .outValid_r(trValid[k]),
      .outEven_r(trEven[k]),
      .outWord_r(trWord[k])
    );

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        oddHold_r[k] <= '0;
        laneFrame[k*2*SW +: 2*SW] <= '0;
      end else if (ce && trValid[k]) begin
        if (!trEven[k]) begin
          oddHold_r[k] <= trWord[k];
        end else begin
          // Odd word in the upper slot goes out first, MSB-first
          laneFrame[k*2*SW +: 2*SW] <= {oddHold_r[k], trWord[k]};
        end
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        chanAnaPdn[2*k +: 2] <= 2'b00;
        chanHpfEn[2*k +: 2] <= 2'b00;
        chanHpfCorner[2*k*CORNER_W +: 2*CORNER_W] <= '0;
      end else if (ce) begin
        chanAnaPdn[2*k +: 2] <= {2{pdnAna_r[k]}};
        chanHpfEn[2*k +: 2] <= {2{hpfEn_r[k/HPF_GROUP]}};
        chanHpfCorner[2*k*CORNER_W +: 2*CORNER_W] <=
            {2{hpfCorner_r[(k/HPF_GROUP)*CORNER_W +: CORNER_W]}};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      frameValid <= 1'b0;
    end else if (ce) begin
      frameValid <= trValid[0] && trEven[0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_phase_alternate: assert property (ce && mode32_r && convValid |=>
      muxSelEven != $past(muxSelEven)) else $error("phase did not alternate");
  a_rate_locked: assert property (mode32_r |-> !rateSel2x)
      else $error("doubled rate selected in 32-input mode");
  a_frame_after_even: assert property (ce && trValid[0] && trEven[0] |=>
      frameValid) else $error("frame missing after even word");
  a_odd_slot: assert property (ce && trValid[0] && !trEven[0] ##1
      ce && trValid[0] && trEven[0] |=>
      laneFrame[2*SW-1:SW] == $past(trWord[0], 2)) else $error("odd slot wrong");
  a_even_slot: assert property (ce && trValid[0] && trEven[0] |=>
      laneFrame[SW-1:0] == $past(trWord[0])) else $error("even slot wrong");
  a_trim_route: assert property (ce && mode32_r && convValid &&
      phase_r == PH_EVEN |=> trEven[0] && trValid[0]) else $error("trim route");
  a_pdn_both: assert property (ce && convValid && mode32_r && pdnDig_r[0]
      |=> trWord[0] == '0) else $error("powered-down word not zero");
  a_ana_pair: assert property (ce ##1 ce |-> chanAnaPdn[1:0] ==
      {2{$past(pdnAna_r[0])}}) else $error("analog power-down split");
  a_hpf_group: assert property (ce && $past(ce) && $stable(hpfEn_r) |->
      chanHpfEn[2*HPF_GROUP-1:0] == {(2*HPF_GROUP){hpfEn_r[0]}})
      else $error("high-pass enable not shared by group");
  a_order_first: assert property (ce && frameValid |->
      laneFrame[2*SW-1:SW] == oddHold_r[0]) else $error("odd word not first");

  c_frame: cover property (frameValid);
  c_refused: cover property (rateReq);
  c_pdn_frame: cover property (frameValid && pdnDig_r[0]);
  c_bad_write: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);

endmodule // dicm_mapper_top
`default_nettype wire

// ===== dicm_lane_rx.sv
// Receiver model that splits each lane frame into its odd and even words
`timescale 1ns/1ps
`default_nettype none
module dicm_lane_rx
  import dicm_pkg::*;
#(
  parameter int NCONV = NUM_CONV,
  parameter int SW = SAMPLE_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Incoming frames
  input wire logic frameValid,
  input wire logic [NCONV*2*SW-1:0] laneFrame,
  // Demultiplexed words
  output logic rxValid,
  output logic [NCONV*SW-1:0] rxOdd,
  output logic [NCONV*SW-1:0] rxEven
);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxValid <= 1'b0;
      rxOdd <= '0;
      rxEven <= '0;
    end else begin
      rxValid <= frameValid;
      for (int k = 0; k < NCONV; k++) begin
        if (frameValid) begin
          // First half on the wire is the odd word
          rxOdd[k*SW +: SW] <= laneFrame[k*2*SW+SW +: SW];
          rxEven[k*SW +: SW] <= laneFrame[k*2*SW +: SW];
        end
      end
    end
  end
endmodule // dicm_lane_rx
`default_nettype wire

// ===== dual_input_channel_mapper_test.sv
// Self-checking testbench of the dual-input channel mapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  mismatches++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module dual_input_channel_mapper_test
  import dicm_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  localparam int NC = 4;
  localparam int SW = SAMPLE_W;
  logic clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, convValid = 1'b0;
  logic [NC*SW-1:0] convData = '0;
  logic muxSelEven, rateSel2x, frameValid;
  logic [2*NC-1:0] chanAnaPdn, chanHpfEn;
  logic [2*NC*CORNER_W-1:0] chanHpfCorner;
  logic [NC*2*SW-1:0] laneFrame;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, rxValid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NC*SW-1:0] rxOdd, rxEven;
  logic [7:0] go [NC], oo [NC], ge [NC], oe [NC];
  logic [NC-1:0] pdnDig = '0;
  logic [2*NC*SW-1:0] expq [$];
  logic [2*NC*SW-1:0] expf;
  int mismatches = 0, cmp_count = 0, cyc = 0;

  always #10 clk_sys = ~clk_sys;

  dicm_mapper_top #(.NCONV(NC), .SW(SW)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .convValid(convValid),
    .convData(convData), .muxSelEven(muxSelEven), .rateSel2x(rateSel2x),
    .chanAnaPdn(chanAnaPdn), .chanHpfEn(chanHpfEn),
    .chanHpfCorner(chanHpfCorner), .frameValid(frameValid),
    .laneFrame(laneFrame), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  dicm_lane_rx #(.NCONV(NC), .SW(SW)) rxModel (
    .clk_sys(clk_sys), .nrst(nrst), .frameValid(frameValid),
    .laneFrame(laneFrame), .rxValid(rxValid), .rxOdd(rxOdd),
    .rxEven(rxEven));

  // ****************************************
  // Closing, timeout and frame monitor
  // ****************************************
  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  always @(posedge clk_sys) begin
    if (rxValid === 1'b1) begin
      if (expq.size() == 0) `CHK("extra frame", 1'b0, 1'b1)
      else begin
        expf = expq.pop_front();
        `CHK("frame", expf, {rxOdd, rxEven})
      end
    end
  end

  // ****************************************
  // Bus and stream tasks
  // ****************************************
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic aw, w, done;
    aw = 1'b1;
    w = 1'b1;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (bvalid === 1'b1) begin
        `CHK("bresp", er, bresp)
        done = 1'b1;
      end
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (rvalid === 1'b1) begin
        `CHK("rdata", ed, rdata)
        `CHK("rresp", er, rresp)
        done = 1'b1;
      end
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end
  endtask

  function automatic logic [SW-1:0] trimw(logic [SW-1:0] s, logic [7:0] g,
                                          logic [7:0] o);
    int p;
    p = ($signed(s) * (int'(g) + 128)) >>> 8;
    return SW'(p + int'($signed(o)));
  endfunction

  task automatic send_pair();
    logic [NC*SW-1:0] od, ev, xo, xe;
    for (int k = 0; k < NC; k++) begin
      od[k*SW +: SW] = SW'($urandom);
      ev[k*SW +: SW] = SW'($urandom);
      xo[k*SW +: SW] = pdnDig[k] ? '0 : trimw(od[k*SW +: SW], go[k], oo[k]);
      xe[k*SW +: SW] = pdnDig[k] ? '0 : trimw(ev[k*SW +: SW], ge[k], oe[k]);
    end
    expq.push_back({xo, xe});
    convData <= od;
    convValid <= 1'b1;
    @(posedge clk_sys);
    `CHK("mux odd", 1'b0, muxSelEven)
    convData <= ev;
    @(posedge clk_sys);
    `CHK("mux even", 1'b1, muxSelEven)
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h5630F1AA));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    axi_rd(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_TRIM_BASE, 32'h0000_8000, RESP_OKAY);
    axi_rd(12'h040, 32'h0000_0000, RESP_SLVERR);
    axi_wr(12'h040, 32'hFFFF_FFFF, RESP_SLVERR);
    for (int k = 0; k < NC; k++) begin
      {go[k], oo[k], ge[k], oe[k]} = $urandom;
      axi_wr(ADDR_TRIM_BASE + 12'(8*k), {16'h0, go[k], oo[k]}, RESP_OKAY);
      axi_wr(ADDR_TRIM_BASE + 12'(8*k+4), {16'h0, ge[k], oe[k]}, RESP_OKAY);
    end
    repeat (6) send_pair();
    convValid <= 1'b0;
    repeat (4) @(posedge clk_sys);
    // Digital power-down on converters 0 and 1, analog on 0 and 2
    pdnDig = 4'h3;
    axi_wr(ADDR_PDN, 32'h0005_0003, RESP_OKAY);
    @(posedge clk_sys);
    `CHK("ana pdn", 8'h33, chanAnaPdn)
    repeat (2) send_pair();
    // Clock enable low freezes phase and the frame pipeline
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("frozen phase", 1'b0, muxSelEven)
    ce <= 1'b1;
    convValid <= 1'b0;
    axi_wr(ADDR_HPF, 32'h0000_0051, RESP_OKAY);
    @(posedge clk_sys);
    `CHK("hpf en", 8'hFF, chanHpfEn)
    `CHK("hpf corner", {8{3'h5}}, chanHpfCorner)
    // Doubled rate requested while in 32-input mode
    axi_wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    @(posedge clk_sys);
    `CHK("rate in mode32", 1'b0, rateSel2x)
    axi_rd(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0000_0002, RESP_OKAY);
    axi_wr(ADDR_STATUS, 32'h0000_0002, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0000_0000, RESP_OKAY);
    // Outside 32-input mode conversions give no frames
    axi_wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
    @(posedge clk_sys);
    `CHK("rate out of mode32", 1'b1, rateSel2x)
    convValid <= 1'b1;
    repeat (3) @(posedge clk_sys);
    convValid <= 1'b0;
    axi_wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    @(posedge clk_sys);
    `CHK("rate back", 1'b0, rateSel2x)
    send_pair();
    convValid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    `CHK("frames left", 0, expq.size())
    end_of_test();
  end
endmodule // dual_input_channel_mapper_test
`default_nettype wire
